//--- design/pxmc_pkg.sv
package pxmc_pkg;
	localparam logic [11:0] OFS_IFC_B = 12'h301;
	localparam logic [11:0] OFS_MAC_A = 12'h400;
	localparam logic [11:0] OFS_MAC_B = 12'h401;

	localparam int IFB_SLOW = 6;
	localparam int IFB_ING_DLY = 4;
	localparam int IFB_EG_DLY = 3;
	localparam int IFB_ROLE = 2;
	localparam int IFB_TYPE = 0;
	localparam int MAC_A_STORM = 1;
	localparam int MAC_A_JUMBO = 0;
	localparam int MAC_B_BP = 3;
	localparam int MAC_B_PASS = 0;

	localparam logic [7:0] IFB_RST = 8'h08;
	localparam logic [7:0] MAC_A_RST = 8'h00;
	localparam logic [7:0] MAC_B_RST = 8'h00;
	localparam logic [7:0] MAC_A_WMASK = 8'h0B;
	localparam logic [7:0] MAC_B_WMASK = 8'hBF;

	localparam logic [13:0] JUMBO_PAYLOAD = 14'h2328;
	localparam logic [13:0] STD_PAYLOAD = 14'h05DC;

	localparam int CLK_KHZ = 250000;
	localparam int RMII_REF_KHZ = 50000;
	localparam int MII100_KHZ = 25000;
	localparam int MII10_KHZ = 2500;
	localparam logic [6:0] DIV_RMII = 7'(CLK_KHZ / RMII_REF_KHZ);
	localparam logic [6:0] DIV_MII100 = 7'(CLK_KHZ / MII100_KHZ);
	localparam logic [6:0] DIV_MII10 = 7'(CLK_KHZ / MII10_KHZ);

	localparam int CLK_PS = 4000;
	localparam int RGMII_DELAY_PS = 1500;
	localparam int DLY_CYC_I = (RGMII_DELAY_PS + CLK_PS - 1) / CLK_PS;
	localparam int DLY_CYC = (DLY_CYC_I < 1) ? 1 : DLY_CYC_I;

	typedef enum logic [1:0] {
		IF_RGMII = 2'b00,
		IF_RMII = 2'b01,
		IF_MII = 2'b10
	} pxmc_if_t;

	typedef enum logic [1:0] {
		SPD_10 = 2'b00,
		SPD_100 = 2'b01,
		SPD_1000 = 2'b10
	} pxmc_speed_t;

	typedef struct packed {
		logic slow;
		logic role;
		logic [1:0] itype;
	} pxmc_strap_t;

	typedef struct packed {
		logic forward;
		logic mirror_only;
		logic drop;
	} pxmc_verdict_t;
endpackage : pxmc_pkg

//--- design/pxmc_strap_sync.sv
`timescale 1ns/10ps
module pxmc_strap_sync
	import pxmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire pxmc_strap_t strap_pins_i,
	output pxmc_strap_t strap_o,
	output logic load_o
);
	pxmc_strap_t meta_reg;
	pxmc_strap_t sync_reg;
	logic [1:0] settle_reg;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= strap_pins_i;
			sync_reg <= meta_reg;
		end
	end

	// one load pulse once the synchroniser holds pin values taken after release
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			settle_reg <= 2'h0;
			load_o <= 1'b0;
		end else begin
			if (settle_reg != 2'h3) begin
				settle_reg <= settle_reg + 2'h1;
			end
			load_o <= (settle_reg == 2'h2);
		end
	end

	assign strap_o = sync_reg;
endmodule : pxmc_strap_sync

//--- design/pxmc_port_cfg.sv
`timescale 1ns/10ps
module pxmc_port_cfg
	import pxmc_pkg::*;
#(
	parameter bit PORT_SIX = 1'b1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic speed_strap_pin_i,
	input wire logic role_strap_pin_i,
	input wire logic [1:0] interface_type_strap_pins_i,
	input wire logic mac_speed_100_i,
	input wire logic half_duplex_i,
	input wire logic fc_filter_disable_i,
	input wire logic receive_clock_pin_i,
	output logic receive_clock_pin_o,
	output logic receive_clock_pin_oe_n_o,
	output pxmc_if_t interface_type_o,
	output pxmc_speed_t link_speed_o,
	output logic mac_role_o,
	output logic ingress_clock_delay_enable_o,
	output logic egress_clock_delay_enable_o,
	output logic storm_protect_o,
	output logic backpressure_active_o,
	output logic [13:0] max_payload_o,
	input wire logic frame_done_i,
	input wire logic [13:0] frame_payload_len_i,
	input wire logic frame_crc_err_i,
	input wire logic frame_undersize_i,
	input wire logic frame_is_bcast_i,
	input wire logic storm_limit_hit_i,
	input wire logic frame_is_flow_ctrl_i,
	output logic verdict_valid_o,
	output pxmc_verdict_t verdict_o
);
	logic [7:0] ifc_b_reg;
	logic [7:0] mac_a_reg;
	logic [7:0] mac_b_reg;
	pxmc_strap_t strap;
	logic strap_load;
	logic [6:0] div_cnt_reg;
	logic [6:0] div_period;
	logic clk_gen;
	logic drive_clk;
	logic [DLY_CYC-1:0] dly_pipe_reg;
	pxmc_if_t if_sel;
	logic oversize;
	logic bad_frame;
	pxmc_verdict_t verdict_next;

	pxmc_strap_sync u_strap (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.strap_pins_i({speed_strap_pin_i, role_strap_pin_i, interface_type_strap_pins_i}),
		.strap_o(strap),
		.load_o(strap_load)
	);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ifc_b_reg <= IFB_RST;
		end else if (reg_wr_i && reg_addr_i == OFS_IFC_B) begin
			ifc_b_reg <= reg_wdata_i;
		end else if (strap_load && PORT_SIX) begin
			ifc_b_reg[IFB_SLOW] <= strap.slow;
			ifc_b_reg[IFB_ROLE] <= strap.role;
			ifc_b_reg[IFB_TYPE +: 2] <= strap.itype;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mac_a_reg <= MAC_A_RST;
			mac_b_reg <= MAC_B_RST;
		end else if (reg_wr_i) begin
			// read-only reserved bits stay at reset value
			if (reg_addr_i == OFS_MAC_A) begin
				mac_a_reg <= reg_wdata_i & MAC_A_WMASK;
			end
			if (reg_addr_i == OFS_MAC_B) begin
				mac_b_reg <= reg_wdata_i & MAC_B_WMASK;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_IFC_B: begin
					reg_rdata_o <= ifc_b_reg;
				end
				OFS_MAC_A: begin
					reg_rdata_o <= mac_a_reg;
				end
				OFS_MAC_B: begin
					reg_rdata_o <= mac_b_reg;
				end
				default: begin
					reg_rdata_o <= 8'h00;
				end
			endcase
		end
	end

	// both upper codes mean MII
	assign if_sel = ifc_b_reg[IFB_TYPE + 1] ? IF_MII : pxmc_if_t'(ifc_b_reg[IFB_TYPE +: 2]);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			interface_type_o <= IF_RGMII;
			link_speed_o <= SPD_1000;
			mac_role_o <= 1'b0;
			ingress_clock_delay_enable_o <= 1'b0;
			egress_clock_delay_enable_o <= 1'b1;
			storm_protect_o <= 1'b0;
			backpressure_active_o <= 1'b0;
			max_payload_o <= STD_PAYLOAD;
		end else begin
			interface_type_o <= if_sel;
			if (!ifc_b_reg[IFB_SLOW]) begin
				link_speed_o <= SPD_1000;
			end else begin
				link_speed_o <= mac_speed_100_i ? SPD_100 : SPD_10;
			end
			mac_role_o <= ifc_b_reg[IFB_ROLE];
			ingress_clock_delay_enable_o <= ifc_b_reg[IFB_ING_DLY];
			egress_clock_delay_enable_o <= ifc_b_reg[IFB_EG_DLY];
			storm_protect_o <= mac_a_reg[MAC_A_STORM];
			// pause control is a separate enable and is not touched here
			backpressure_active_o <= mac_b_reg[MAC_B_BP] && half_duplex_i;
			max_payload_o <= mac_a_reg[MAC_A_JUMBO] ? JUMBO_PAYLOAD : STD_PAYLOAD;
		end
	end

	// the device drives the pin only as RMII reference source or as MII PHY
	assign drive_clk = PORT_SIX && !ifc_b_reg[IFB_ROLE] && (if_sel != IF_RGMII);

	always_comb begin
		case (if_sel)
			IF_RMII: begin
				div_period = DIV_RMII;
			end
			IF_MII: begin
				div_period = mac_speed_100_i ? DIV_MII100 : DIV_MII10;
			end
			default: begin
				div_period = DIV_RMII;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_cnt_reg <= 7'h00;
		end else if (!drive_clk || div_cnt_reg >= div_period - 7'h01) begin
			div_cnt_reg <= 7'h00;
		end else begin
			div_cnt_reg <= div_cnt_reg + 7'h01;
		end
	end

	// odd ratios give a duty cycle slightly under half
	assign clk_gen = drive_clk && (div_cnt_reg < (div_period >> 1));

	// whole system cycles are the finest step, so the delay is one period or more
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dly_pipe_reg <= '0;
		end else begin
			// newest sample enters at the top, bit 0 is the oldest
			dly_pipe_reg <= DLY_CYC'({clk_gen, dly_pipe_reg} >> 1);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			receive_clock_pin_o <= 1'b0;
			receive_clock_pin_oe_n_o <= 1'b1;
		end else begin
			receive_clock_pin_o <= ifc_b_reg[IFB_EG_DLY] ? dly_pipe_reg[0] : clk_gen;
			receive_clock_pin_oe_n_o <= !drive_clk;
		end
	end

	assign oversize = frame_payload_len_i > (mac_a_reg[MAC_A_JUMBO] ? JUMBO_PAYLOAD : STD_PAYLOAD);
	assign bad_frame = frame_crc_err_i || frame_undersize_i || oversize;

	always_comb begin
		verdict_next = '0;
		if (frame_is_flow_ctrl_i) begin
			verdict_next.forward = fc_filter_disable_i;
			verdict_next.drop = !fc_filter_disable_i;
		end else if (mac_a_reg[MAC_A_STORM] && frame_is_bcast_i && storm_limit_hit_i) begin
			verdict_next.drop = 1'b1;
		end else if (bad_frame) begin
			verdict_next.mirror_only = mac_b_reg[MAC_B_PASS];
			verdict_next.drop = !mac_b_reg[MAC_B_PASS];
		end else begin
			verdict_next.forward = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			verdict_valid_o <= 1'b0;
			verdict_o <= '0;
		end else begin
			verdict_valid_o <= frame_done_i;
			if (frame_done_i) begin
				verdict_o <= verdict_next;
			end
		end
	end
endmodule : pxmc_port_cfg

//--- dv/pxmc_port_cfg_checker.sv
`timescale 1ns/10ps
module pxmc_port_cfg_checker
	import pxmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic mac_speed_100_i,
	input wire logic half_duplex_i,
	input wire logic fc_filter_disable_i,
	input wire logic frame_done_i,
	input wire logic frame_is_flow_ctrl_i,
	input wire logic receive_clock_pin_oe_n_o,
	input wire pxmc_if_t interface_type_o,
	input wire pxmc_speed_t link_speed_o,
	input wire logic mac_role_o,
	input wire logic storm_protect_o,
	input wire logic backpressure_active_o,
	input wire logic [13:0] max_payload_o,
	input wire pxmc_verdict_t verdict_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_rdonly_zero: assert property (reg_rd_i && reg_addr_i == OFS_MAC_A |=>
		reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[2]) else $error("read-only bits not zero");
	a_jumbo_limit: assert property (reg_wr_i && reg_addr_i == OFS_MAC_A |-> ##2
		max_payload_o == ($past(reg_wdata_i[0], 2) ? JUMBO_PAYLOAD : STD_PAYLOAD))
		else $error("payload limit wrong");
	a_storm_follow: assert property (reg_wr_i && reg_addr_i == OFS_MAC_A |-> ##2
		storm_protect_o == $past(reg_wdata_i[1], 2)) else $error("storm enable wrong");
	a_bp_full_duplex: assert property (!half_duplex_i |=> !backpressure_active_o)
		else $error("back pressure in full duplex");
	a_fc_pass_free: assert property (frame_done_i && frame_is_flow_ctrl_i |=>
		verdict_o.forward == $past(fc_filter_disable_i) && !verdict_o.mirror_only)
		else $error("flow control verdict wrong");
	a_role_release: assert property (mac_role_o [*3] |-> receive_clock_pin_oe_n_o)
		else $error("clock pin driven in receive role");
	a_type_decode: assert property (reg_wr_i && reg_addr_i == OFS_IFC_B |-> ##2
		interface_type_o == ($past(reg_wdata_i[1], 2) ? IF_MII : pxmc_if_t'($past(reg_wdata_i[1:0], 2))))
		else $error("interface type wrong");
	a_slow_speed: assert property (mac_speed_100_i [*3] ##0 (link_speed_o != SPD_1000) |->
		link_speed_o == SPD_100) else $error("slow speed wrong");
endmodule : pxmc_port_cfg_checker

bind pxmc_port_cfg pxmc_port_cfg_checker i_pxmc_port_cfg_checker (.*);

//--- dv/pxmc_phy_model.sv
`timescale 1ns/10ps
module pxmc_phy_model (
	input wire logic drive_n_i,
	input wire logic dev_clk_i,
	output logic pin_o
);
	logic ref_clk = 1'h0;
	// external 50 MHz reference; it also keeps a released pin moving
	always #10 ref_clk = ~ref_clk;
	assign pin_o = drive_n_i ? ref_clk : dev_clk_i;
endmodule : pxmc_phy_model

//--- dv/pxmc_port_cfg_tb.sv
`timescale 1ns/10ps
module pxmc_port_cfg_tb;
	import pxmc_pkg::*;
	logic clk_i = 1'h0, rstn_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
	logic speed_strap_pin_i = 1'h1, role_strap_pin_i = 1'h0, mac_speed_100_i = 1'h1;
	logic [1:0] interface_type_strap_pins_i = 2'h1;
	logic half_duplex_i = 1'h1, fc_filter_disable_i = 1'h0, frame_done_i = 1'h0;
	logic frame_crc_err_i = 1'h0, frame_undersize_i = 1'h0, frame_is_bcast_i = 1'h0;
	logic storm_limit_hit_i = 1'h0, frame_is_flow_ctrl_i = 1'h0;
	logic [13:0] frame_payload_len_i = 14'h0000, max_payload_o, lim;
	logic receive_clock_pin_i, receive_clock_pin_o, receive_clock_pin_oe_n_o, mac_role_o;
	logic ingress_clock_delay_enable_o, egress_clock_delay_enable_o, storm_protect_o;
	logic backpressure_active_o, verdict_valid_o;
	logic [2:0] e;
	logic [31:0] seed = 32'hDD4836A2, r;
	pxmc_if_t interface_type_o;
	pxmc_speed_t link_speed_o;
	pxmc_verdict_t verdict_o;
	int mismatches = 0, samples_checked = 0, ma = 0, mb = 0;

	pxmc_port_cfg #(.PORT_SIX(1'h1)) i_pxmc_port_cfg (.*);
	pxmc_phy_model i_pxmc_phy_model (.drive_n_i(receive_clock_pin_oe_n_o),
		.dev_clk_i(receive_clock_pin_o), .pin_o(receive_clock_pin_i));

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// returns two edges after the strobe, when decoded outputs have settled
	task automatic wrr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'h1;
		@(negedge clk_i);
		reg_wr_i = 1'h0;
		@(negedge clk_i);
	endtask : wrr

	task automatic rdr(input logic [11:0] a, input logic [7:0] x);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'h1;
		@(negedge clk_i);
		reg_rd_i = 1'h0;
		chk(16'(reg_rdata_o), 16'(x));
	endtask : rdr

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end

	initial begin
		repeat (16) @(negedge clk_i);
		rstn_i = 1'h1;
		repeat (8) @(negedge clk_i);
		rdr(OFS_IFC_B, 8'h49);
		chk(16'({ingress_clock_delay_enable_o, egress_clock_delay_enable_o, receive_clock_pin_oe_n_o}), 16'h2);
		rdr(OFS_MAC_B, 8'h00);
		rdr(12'h302, 8'h00);
		wrr(OFS_MAC_A, 8'hFF);
		rdr(OFS_MAC_A, 8'h0B);
		chk(16'({storm_protect_o, max_payload_o}), 16'({1'h1, JUMBO_PAYLOAD}));
		wrr(OFS_MAC_B, 8'hFF);
		rdr(OFS_MAC_B, 8'hBF);
		chk(16'(backpressure_active_o), 16'h1);
		$display("register test done");
		for (int t = 0; t < 8; t++) begin
			wrr(OFS_IFC_B, 8'(t));
			@(negedge clk_i);
			chk(16'({interface_type_o, link_speed_o, receive_clock_pin_oe_n_o}),
				16'({t[1] ? 2'h2 : 2'(t), 2'h2, t[2] | (t[1:0] == 2'h0)}));
		end
		wrr(OFS_IFC_B, 8'h40);
		chk(16'(link_speed_o), 16'(SPD_100));
		mac_speed_100_i = 1'h0;
		repeat (3) @(negedge clk_i);
		chk(16'(link_speed_o), 16'(SPD_10));
		$display("interface test done");
		// generated reference as seen at the pin, without and with egress delay
		for (int m = 0; m < 2; m++) begin
			wrr(OFS_IFC_B, (m == 1) ? 8'h09 : 8'h01);
			ma = 0;
			repeat (10) begin
				@(negedge clk_i);
				ma += int'(receive_clock_pin_i);
			end
			chk(16'(ma), 16'(10 / CLK_KHZ * RMII_REF_KHZ * 0 + 4));
		end
		wrr(OFS_IFC_B, 8'h05);
		chk(16'({receive_clock_pin_oe_n_o, receive_clock_pin_o}), 16'h2);
		$display("clock pin test done");
		for (int n = 0; n < 400; n++) begin
			r = rnd();
			if (n % 50 == 0) begin
				ma = {r[0], r[0]};
				mb = r[1];
				wrr(OFS_MAC_A, 8'(ma));
				wrr(OFS_MAC_B, 8'(mb));
			end
			lim = ma[0] ? JUMBO_PAYLOAD : STD_PAYLOAD;
			@(negedge clk_i);
			frame_done_i = 1'h1;
			half_duplex_i = r[11];
			frame_payload_len_i = lim + 14'(r[9:8]) - 14'h2;
			{frame_crc_err_i, frame_undersize_i, frame_is_bcast_i} = {r[12] & r[13], r[14] & r[15], r[4]};
			{storm_limit_hit_i, frame_is_flow_ctrl_i, fc_filter_disable_i} = {r[5], r[6] & r[7], r[2]};
			if (frame_is_flow_ctrl_i)
				e = {fc_filter_disable_i, 1'h0, !fc_filter_disable_i};
			else if (ma[1] && frame_is_bcast_i && storm_limit_hit_i)
				e = 3'h1;
			else if (frame_crc_err_i || frame_undersize_i || frame_payload_len_i > lim)
				e = mb[0] ? 3'h2 : 3'h1;
			else
				e = 3'h4;
			@(negedge clk_i);
			frame_done_i = 1'h0;
			chk(16'({verdict_valid_o, verdict_o}), 16'({1'h1, e}));
		end
		$display("frame test done");
		print_verdict();
	end
endmodule : pxmc_port_cfg_tb
